// ===== hdl/sea_bus_if.sv
// Conditioned bus events passed from the line conditioner to the protocol core.
`timescale 1ns/1ps
interface sea_bus_if;
  logic scl_rise;
  logic scl_fall;
  logic start;
  logic stop;
  logic sda;
  logic wp;
  logic sel_hi;
  logic sel_lo;
  modport cond  (output scl_rise, scl_fall, start, stop, sda, wp, sel_hi, sel_lo);
  modport proto (input  scl_rise, scl_fall, start, stop, sda, wp, sel_hi, sel_lo);
endinterface : sea_bus_if

// ===== hdl/sea_consts.svh
// Constants of the two-wire serial EEPROM slave.
`ifndef SEA_CONSTS_SVH
`define SEA_CONSTS_SVH

`define SEA_TYPE_ID        4'ha
`define SEA_TYPE_MSB       7
`define SEA_TYPE_LSB       4
`define SEA_SEL_HI_BIT     3
`define SEA_SEL_LO_BIT     2
`define SEA_TOP_BIT        1
`define SEA_RW_BIT         0
`define SEA_PAGES          512
`define SEA_PAGE_BYTES     256
`define SEA_ADDR_BITS      17
`define SEA_CLK_PERIOD_NS  4
`define SEA_T_WR_NS        5000000
`define SEA_WR_CYCLES      (`SEA_T_WR_NS / `SEA_CLK_PERIOD_NS)
`define SEA_BYTE_BITS      4'h8
`define SEA_SYNC_RST       5'h18

`endif

// ===== hdl/sea_eeprom.sv
// Two-wire serial EEPROM slave: addressing, page write, self-timed programming.
`timescale 1ns/1ps
`include "sea_consts.svh"
module sea_eeprom #(
  parameter int PAGES      = `SEA_PAGES,
  parameter int PAGE_BYTES = `SEA_PAGE_BYTES,
  parameter int WR_CYCLES  = `SEA_WR_CYCLES
) (
  input  wire logic clock,
  input  wire logic rstn,
  input  wire logic scl_pin,
  input  wire logic sda_pin_in,
  output wire logic sda_pin_out,
  output wire logic sda_pin_oe,
  input  wire logic write_protect,
  input  wire logic select_pin_high,
  input  wire logic select_pin_low,
  output wire logic standby,
  output wire logic busy
);
  localparam int AW = `SEA_ADDR_BITS;
  localparam int PW = $clog2(PAGE_BYTES);
  localparam int CW = $clog2(WR_CYCLES + 1);

  // The device address byte and the two word address bytes give a 17-bit address, with the row at bits 16:8.
  if (PAGES * PAGE_BYTES != (1 << AW) || PW > 8 || (1 << PW) != PAGE_BYTES) begin : g_bad_geom
    $error("sea_eeprom: page geometry must give a 17-bit byte address");
  end
  if (WR_CYCLES < PAGE_BYTES) begin : g_bad_wr
    $error("sea_eeprom: write cycle shorter than one page copy");
  end

  typedef struct packed {
    sea_pkg::sea_state_t state;
    logic [7:0]          shreg;
    logic [3:0]          bitcnt;
    logic                ack_ph;
    logic                sda_oe;
    logic                rw;
    logic                nack;
    logic [AW-1:0]       addr;
    logic [PAGE_BYTES-1:0] pend;
    logic [CW-1:0]       prog_cnt;
  } sea_core_t;

  sea_core_t core_reg;
  sea_core_t core_next;

  sea_bus_if ev ();

  sea_line_cond u_cond (
    .clock           (clock),
    .rstn            (rstn),
    .scl_pin         (scl_pin),
    .sda_pin         (sda_pin_in),
    .write_protect   (write_protect),
    .select_pin_high (select_pin_high),
    .select_pin_low  (select_pin_low),
    .ev              (ev)
  );

  logic [7:0]    mem  [PAGES*PAGE_BYTES];
  logic [7:0]    pbuf [PAGE_BYTES];
  logic [7:0]    mem_rd;
  logic [PW-1:0] prog_idx;
  logic          buf_we;
  logic          mem_we;
  logic          dev_eval;
  logic          dev_match;
  logic          data_commit;
  logic          prog_go;

  assign mem_rd   = mem[core_reg.addr];
  assign prog_idx = core_reg.prog_cnt[PW-1:0];
  assign dev_eval = core_reg.state == sea_pkg::st_dev && ev.scl_fall && !core_reg.ack_ph
                    && core_reg.bitcnt == `SEA_BYTE_BITS;
  assign dev_match = core_reg.shreg[`SEA_TYPE_MSB:`SEA_TYPE_LSB] == `SEA_TYPE_ID
                     && core_reg.shreg[`SEA_SEL_HI_BIT] == ev.sel_hi
                     && core_reg.shreg[`SEA_SEL_LO_BIT] == ev.sel_lo;
  assign data_commit = core_reg.state == sea_pkg::st_data && ev.scl_fall && !core_reg.ack_ph
                       && core_reg.bitcnt == `SEA_BYTE_BITS;
  assign prog_go = ev.stop && core_reg.state == sea_pkg::st_data && !core_reg.ack_ph
                   && |core_reg.pend && !ev.wp;

  always_comb begin
    core_next = core_reg;
    buf_we    = 1'b0;
    mem_we    = 1'b0;
    if (ev.start && core_reg.state != sea_pkg::st_prog) begin
      // A start aborts any transfer and drops bytes not yet closed by a stop.
      core_next.state  = sea_pkg::st_dev;
      core_next.bitcnt = 4'h0;
      core_next.ack_ph = 1'b0;
      core_next.sda_oe = 1'b0;
      core_next.pend   = '0;
    end else if (ev.stop && core_reg.state != sea_pkg::st_prog) begin
      core_next.sda_oe = 1'b0;
      core_next.ack_ph = 1'b0;
      if (prog_go) begin
        core_next.state    = sea_pkg::st_prog;
        core_next.prog_cnt = '0;
      end else begin
        core_next.state = sea_pkg::st_idle;
        core_next.pend  = '0;
      end
    end else begin
      case (core_reg.state)
        sea_pkg::st_idle: begin
          core_next.sda_oe = 1'b0;
        end
        sea_pkg::st_prog: begin
          // The bus is not watched here, so polls go unanswered until the end.
          core_next.prog_cnt = core_reg.prog_cnt + 1'b1;
          if (core_reg.prog_cnt < CW'(PAGE_BYTES)) begin
            mem_we = core_reg.pend[prog_idx];
          end
          if (core_reg.prog_cnt == CW'(WR_CYCLES - 1)) begin
            core_next.state = sea_pkg::st_idle;
            core_next.pend  = '0;
          end
        end
        sea_pkg::st_dev, sea_pkg::st_whi, sea_pkg::st_wlo, sea_pkg::st_data: begin
          if (ev.scl_rise && !core_reg.ack_ph) begin
            core_next.shreg  = {core_reg.shreg[6:0], ev.sda};
            core_next.bitcnt = core_reg.bitcnt + 4'h1;
          end else if (ev.scl_fall && !core_reg.ack_ph && core_reg.bitcnt == `SEA_BYTE_BITS) begin
            core_next.ack_ph = 1'b1;
            core_next.bitcnt = 4'h0;
            core_next.sda_oe = core_reg.state != sea_pkg::st_dev || dev_match;
            case (core_reg.state)
              sea_pkg::st_dev: begin
                if (dev_match) begin
                  core_next.rw = core_reg.shreg[`SEA_RW_BIT];
                  if (!core_reg.shreg[`SEA_RW_BIT]) begin
                    core_next.addr[AW-1] = core_reg.shreg[`SEA_TOP_BIT];
                  end
                end
              end
              sea_pkg::st_whi: begin
                core_next.addr[15:8] = core_reg.shreg;
              end
              sea_pkg::st_wlo: begin
                core_next.addr[7:0] = core_reg.shreg;
              end
              default: begin
                buf_we = 1'b1;
                core_next.pend[core_reg.addr[PW-1:0]] = 1'b1;
                core_next.addr[PW-1:0] = core_reg.addr[PW-1:0] + 1'b1;
              end
            endcase
          end else if (ev.scl_fall && core_reg.ack_ph) begin
            core_next.ack_ph = 1'b0;
            core_next.sda_oe = 1'b0;
            case (core_reg.state)
              sea_pkg::st_dev: begin
                if (!core_reg.sda_oe) begin
                  core_next.state = sea_pkg::st_idle;
                end else if (core_reg.rw) begin
                  core_next.state  = sea_pkg::st_rd;
                  core_next.shreg  = {mem_rd[6:0], 1'b1};
                  core_next.sda_oe = ~mem_rd[7];
                  core_next.bitcnt = 4'h1;
                  core_next.addr   = core_reg.addr + 1'b1;
                end else begin
                  core_next.state = sea_pkg::st_whi;
                end
              end
              sea_pkg::st_whi: core_next.state = sea_pkg::st_wlo;
              default:         core_next.state = sea_pkg::st_data;
            endcase
          end
        end
        sea_pkg::st_rd: begin
          if (ev.scl_fall && !core_reg.ack_ph) begin
            if (core_reg.bitcnt == `SEA_BYTE_BITS) begin
              core_next.sda_oe = 1'b0;
              core_next.ack_ph = 1'b1;
              core_next.bitcnt = 4'h0;
            end else begin
              core_next.sda_oe = ~core_reg.shreg[7];
              core_next.shreg  = {core_reg.shreg[6:0], 1'b1};
              core_next.bitcnt = core_reg.bitcnt + 4'h1;
            end
          end else if (ev.scl_rise && core_reg.ack_ph) begin
            core_next.nack = ev.sda;
          end else if (ev.scl_fall && core_reg.ack_ph) begin
            core_next.ack_ph = 1'b0;
            if (core_reg.nack) begin
              // Released line lets dummy clocks end in a no-acknowledge.
              core_next.state = sea_pkg::st_idle;
            end else begin
              core_next.shreg  = {mem_rd[6:0], 1'b1};
              core_next.sda_oe = ~mem_rd[7];
              core_next.bitcnt = 4'h1;
              core_next.addr   = core_reg.addr + 1'b1;
            end
          end
        end
        default: begin
          core_next.state  = sea_pkg::st_idle;
          core_next.sda_oe = 1'b0;
        end
      endcase
    end
  end

  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      core_reg <= '0;
    end else begin
      core_reg <= core_next;
    end
  end

  // Page buffer and array hold data only; they carry no reset.
  always_ff @(posedge clock) begin
    if (buf_we) begin
      pbuf[core_reg.addr[PW-1:0]] <= core_reg.shreg;
    end
    if (mem_we) begin
      mem[{core_reg.addr[AW-1:PW], prog_idx}] <= pbuf[prog_idx];
    end
  end

  assign sda_pin_out = 1'b0;
  assign sda_pin_oe  = core_reg.sda_oe;
  assign standby     = core_reg.state == sea_pkg::st_idle;
  assign busy        = core_reg.state == sea_pkg::st_prog;

  default clocking cb @(posedge clock); endclocking
  default disable iff (!rstn);

  property p_ack_match;
    dev_eval && dev_match |=> sda_pin_oe && core_reg.ack_ph;
  endproperty
  a_ack_match: assert property (p_ack_match) else $error("matching address not acknowledged");

  property p_nack_mismatch;
    dev_eval && !dev_match |=> !sda_pin_oe ##1 !sda_pin_oe;
  endproperty
  a_nack_mismatch: assert property (p_nack_mismatch) else $error("mismatched address acknowledged");

  property p_top_bit;
    dev_eval && dev_match && !core_reg.shreg[`SEA_RW_BIT]
      |=> core_reg.addr[AW-1] == $past(core_reg.shreg[`SEA_TOP_BIT]);
  endproperty
  a_top_bit: assert property (p_top_bit) else $error("address top bit not taken");

  property p_hi_byte;
    core_reg.state == sea_pkg::st_whi && ev.scl_fall && !core_reg.ack_ph
      && core_reg.bitcnt == `SEA_BYTE_BITS |=> core_reg.addr[15:8] == $past(core_reg.shreg);
  endproperty
  a_hi_byte: assert property (p_hi_byte) else $error("first word address byte misplaced");

  property p_wrap;
    data_commit |=> core_reg.addr[AW-1:PW] == $past(core_reg.addr[AW-1:PW])
                    && core_reg.addr[PW-1:0] == PW'($past(core_reg.addr[PW-1:0]) + 1'b1);
  endproperty
  a_wrap: assert property (p_wrap) else $error("page address increment wrong");

  property p_prog_start;
    prog_go |=> busy && core_reg.prog_cnt == '0;
  endproperty
  a_prog_start: assert property (p_prog_start) else $error("stop did not start programming");

  property p_wp_skip;
    ev.stop && core_reg.state == sea_pkg::st_data && !core_reg.ack_ph && ev.wp |=> standby;
  endproperty
  a_wp_skip: assert property (p_wp_skip) else $error("protected write not skipped");

  property p_quiet;
    busy |-> !sda_pin_oe ##1 (busy || standby);
  endproperty
  a_quiet: assert property (p_quiet) else $error("device active during programming");

  property p_prog_end;
    busy && core_reg.prog_cnt == CW'(WR_CYCLES - 1) |=> standby;
  endproperty
  a_prog_end: assert property (p_prog_end) else $error("programming length wrong");

  property p_start;
    ev.start && !busy |=> core_reg.state == sea_pkg::st_dev && core_reg.bitcnt == 4'h0
                          && !sda_pin_oe;
  endproperty
  a_start: assert property (p_start) else $error("start not accepted");

  property p_dir;
    core_reg.state == sea_pkg::st_dev && core_reg.ack_ph && core_reg.sda_oe && ev.scl_fall
      && core_reg.rw |=> core_reg.state == sea_pkg::st_rd;
  endproperty
  a_dir: assert property (p_dir) else $error("read direction not taken");

  c_prog: cover property (prog_go ##1 busy);
  c_wp: cover property (ev.stop && core_reg.state == sea_pkg::st_data && ev.wp);
  c_read: cover property (core_reg.state == sea_pkg::st_rd && core_reg.ack_ph);
  c_nack: cover property (dev_eval && !dev_match);
endmodule : sea_eeprom

// ===== hdl/sea_line_cond.sv
// Pin synchronisers and start, stop and clock edge detection.
`timescale 1ns/1ps
`include "sea_consts.svh"
module sea_line_cond (
  input  wire logic clock,
  input  wire logic rstn,
  input  wire logic scl_pin,
  input  wire logic sda_pin,
  input  wire logic write_protect,
  input  wire logic select_pin_high,
  input  wire logic select_pin_low,
  sea_bus_if.cond   ev
);
  typedef struct packed {
    logic [4:0] meta;
    logic [4:0] sync;
    logic       scl_q;
    logic       sda_q;
  } sea_cond_t;

  sea_cond_t cond_reg;
  sea_cond_t cond_next;

  always_comb begin
    cond_next       = cond_reg;
    cond_next.meta  = {scl_pin, sda_pin, write_protect, select_pin_high, select_pin_low};
    cond_next.sync  = cond_reg.meta;
    cond_next.scl_q = cond_reg.sync[4];
    cond_next.sda_q = cond_reg.sync[3];
  end

  // Both lines reset to the idle-high level so release gives no false edge.
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      cond_reg <= {`SEA_SYNC_RST, `SEA_SYNC_RST, 1'b1, 1'b1};
    end else begin
      cond_reg <= cond_next;
    end
  end

  assign ev.scl_rise = cond_reg.sync[4] & ~cond_reg.scl_q;
  assign ev.scl_fall = ~cond_reg.sync[4] & cond_reg.scl_q;
  assign ev.start    = cond_reg.sync[4] & cond_reg.scl_q & cond_reg.sda_q & ~cond_reg.sync[3];
  assign ev.stop     = cond_reg.sync[4] & cond_reg.scl_q & ~cond_reg.sda_q & cond_reg.sync[3];
  assign ev.sda      = cond_reg.sync[3];
  assign ev.wp       = cond_reg.sync[2];
  assign ev.sel_hi   = cond_reg.sync[1];
  assign ev.sel_lo   = cond_reg.sync[0];
endmodule : sea_line_cond

// ===== hdl/sea_pkg.sv
// Types shared by the serial EEPROM slave modules.
package sea_pkg;
  typedef enum logic [2:0] {
    st_idle,
    st_dev,
    st_whi,
    st_wlo,
    st_data,
    st_rd,
    st_prog
  } sea_state_t;
endpackage : sea_pkg

// ===== verification/sea_host_model.sv
// Bus master model that drives the clock and data lines of the EEPROM slave.
`timescale 1ns/1ps
module sea_host_model #(
  parameter int HALF = 8
) (
  input  wire logic       clock,
  input  wire logic       sda_wire,
  output logic            scl,
  output logic            sda_low,
  output logic            ack_stb,
  output logic            ack_seen,
  output logic            rd_stb,
  output logic [7:0]      rd_byte
);
  initial begin
    scl      = 1'b1;
    sda_low  = 1'b0;
    ack_stb  = 1'b0;
    ack_seen = 1'b0;
    rd_stb   = 1'b0;
    rd_byte  = 8'h00;
  end

  task automatic tick(input int n);
    repeat (n) @(posedge clock);
  endtask : tick

  // One clock pulse; the data line is sampled at the end of the high phase.
  task automatic clk_pulse(output logic s);
    scl <= 1'b1;
    tick(HALF);
    s = sda_wire;
    scl <= 1'b0;
    tick(HALF);
  endtask : clk_pulse

  // Works from idle and as a repeated start from a low clock.
  task automatic start_cond();
    sda_low <= 1'b0;
    tick(HALF);
    scl <= 1'b1;
    tick(HALF);
    sda_low <= 1'b1;
    tick(HALF);
    scl <= 1'b0;
    tick(HALF);
  endtask : start_cond

  task automatic stop_cond();
    sda_low <= 1'b1;
    tick(HALF);
    scl <= 1'b1;
    tick(HALF);
    sda_low <= 1'b0;
    tick(HALF);
  endtask : stop_cond

  // Sends a byte MSB first, then releases the line for the slave's answer.
  task automatic send_byte(input logic [7:0] b);
    logic s;
    for (int i = 7; i >= 0; i--) begin
      sda_low <= ~b[i];
      tick(HALF);
      clk_pulse(s);
    end
    sda_low <= 1'b0;
    tick(HALF);
    clk_pulse(s);
    ack_seen <= ~s;
    ack_stb <= 1'b1;
    tick(1);
    ack_stb <= 1'b0;
  endtask : send_byte

  // Receives a byte; more high acknowledges it so the slave continues.
  task automatic recv_byte(input logic more);
    logic       s;
    logic [7:0] v;
    for (int i = 7; i >= 0; i--) begin
      clk_pulse(s);
      v[i] = s;
    end
    sda_low <= more;
    tick(HALF);
    clk_pulse(s);
    sda_low <= 1'b0;
    rd_byte <= v;
    rd_stb <= 1'b1;
    tick(1);
    rd_stb <= 1'b0;
  endtask : recv_byte
endmodule : sea_host_model

// ===== verification/tb_top.sv
// Self-checking bench for the EEPROM slave: addressing, page write, polling and protection.
`timescale 1ns/1ps
module tb_top;
  logic        clock = 1'b0;
  logic        rstn = 1'b0;
  logic        write_protect = 1'b0;
  logic        select_pin_high = 1'b0;
  logic        select_pin_low = 1'b0;
  wire logic   sda_pin_out;
  wire logic   sda_pin_oe;
  wire logic   standby;
  wire logic   busy;
  wire logic   scl;
  wire logic   sda_low;
  wire logic   ack_stb;
  wire logic   ack_seen;
  wire logic   rd_stb;
  wire logic   [7:0] rd_byte;
  wire logic   sda_wire;
  logic        exp_ack_q[$];
  logic [7:0]  exp_rd_q[$];
  logic [31:0] exp_len_q[$];
  logic [31:0] busy_len = 32'h0;
  localparam int WR_LEN = 300;
  logic [31:0] lfsr = 32'hd28f;
  logic [7:0]  d[3];
  logic [1:0]  selv;
  logic [1:0]  sel;
  logic [3:0]  nib;
  logic [7:0]  dev_w;
  logic        s;
  int          fail_count = 0;
  int          n_checks = 0;

  always #2 clock = ~clock;
  assign sda_wire = !(sda_low || (sda_pin_oe && !sda_pin_out));

  sea_eeprom #(.WR_CYCLES(WR_LEN)) sea_eeprom_i (
    .clock(clock), .rstn(rstn), .scl_pin(scl), .sda_pin_in(sda_wire),
    .sda_pin_out(sda_pin_out), .sda_pin_oe(sda_pin_oe), .write_protect(write_protect),
    .select_pin_high(select_pin_high), .select_pin_low(select_pin_low),
    .standby(standby), .busy(busy));
  sea_host_model sea_host_model_i (
    .clock(clock), .sda_wire(sda_wire), .scl(scl), .sda_low(sda_low), .ack_stb(ack_stb),
    .ack_seen(ack_seen), .rd_stb(rd_stb), .rd_byte(rd_byte));

  function automatic logic [31:0] lfsr_next(input logic [31:0] v);
    return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
  endfunction : lfsr_next

  task automatic check_bit(input string name, input logic e, input logic g);
    n_checks++;
    if (g !== e) begin
      fail_count++;
      $display("unexpected %s: expected %b seen %b", name, e, g);
    end
  endtask : check_bit

  task automatic check_byte(input string name, input logic [7:0] e, input logic [7:0] g);
    n_checks++;
    if (g !== e) begin
      fail_count++;
      $display("unexpected %s: expected %h seen %h", name, e, g);
    end
  endtask : check_byte

  task automatic check_word(input string name, input logic [31:0] e, input logic [31:0] g);
    n_checks++;
    if (g !== e) begin
      fail_count++;
      $display("unexpected %s: expected %0d seen %0d", name, e, g);
    end
  endtask : check_word

  task automatic stop_test();
    $display("comparisons %0d mismatches %0d", n_checks, fail_count);
    if (fail_count == 0 && n_checks > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : stop_test

  task automatic tx(input logic [7:0] b, input logic ack);
    exp_ack_q.push_back(ack);
    sea_host_model_i.send_byte(b);
  endtask : tx

  task automatic rx(input logic [7:0] v, input logic more);
    exp_rd_q.push_back(v);
    sea_host_model_i.recv_byte(more);
  endtask : rx

  task automatic levels(input logic e_standby, input logic e_busy);
    check_bit("standby", e_standby, standby);
    check_bit("busy", e_busy, busy);
  endtask : levels

  // Dummy write of the word address, then a repeated start with a read address byte.
  task automatic set_addr(input logic [7:0] hi, input logic [7:0] lo);
    sea_host_model_i.start_cond();
    tx(dev_w, 1'b1);
    tx(hi, 1'b1);
    tx(lo, 1'b1);
    sea_host_model_i.start_cond();
    tx(dev_w | 8'h01, 1'b1);
  endtask : set_addr

  always @(posedge clock) begin
    if (ack_stb === 1'b1) begin
      check_bit("ack", exp_ack_q.pop_front(), ack_seen);
    end
    if (rd_stb === 1'b1) begin
      check_byte("read data", exp_rd_q.pop_front(), rd_byte);
    end
    // The write cycle length is counted in clocks and judged when busy drops.
    if (busy === 1'b1) begin
      busy_len <= busy_len + 32'h1;
    end else if (busy_len != 32'h0) begin
      check_word("write cycle length", exp_len_q.pop_front(), busy_len);
      busy_len <= 32'h0;
    end
  end

  initial begin
    repeat (100000) @(posedge clock);
    fail_count++;
    $display("unexpected run length: expected end seen timeout");
    stop_test();
  end

  initial begin
    repeat (5) @(posedge clock);
    rstn <= 1'b1;
    repeat (4) @(posedge clock);
    levels(1'b1, 1'b0);
    for (int k = 0; k < 8; k++) begin
      lfsr = lfsr_next(lfsr);
      selv = lfsr[1:0];
      {select_pin_high, select_pin_low} <= selv;
      repeat (4) @(posedge clock);
      nib = k[2] ? lfsr[7:4] : 4'ha;
      sel = k[1:0];
      sea_host_model_i.start_cond();
      tx({nib, sel, 2'b00}, (nib == 4'ha) && (sel == selv));
      sea_host_model_i.stop_cond();
      levels(1'b1, 1'b0);
    end
    dev_w = {4'ha, selv, 2'b10};
    for (int i = 0; i < 3; i++) begin
      lfsr = lfsr_next(lfsr);
      d[i] = lfsr[7:0];
    end
    sea_host_model_i.start_cond();
    tx(dev_w, 1'b1);
    tx(8'h12, 1'b1);
    tx(8'hfe, 1'b1);
    for (int i = 0; i < 3; i++) begin
      tx(d[i], 1'b1);
    end
    exp_len_q.push_back(32'(WR_LEN));
    sea_host_model_i.stop_cond();
    levels(1'b0, 1'b1);
    sea_host_model_i.start_cond();
    tx(dev_w, 1'b0);
    sea_host_model_i.stop_cond();
    repeat (320) @(posedge clock);
    levels(1'b1, 1'b0);
    set_addr(8'h12, 8'hfe);
    rx(d[0], 1'b1);
    rx(d[1], 1'b0);
    set_addr(8'h12, 8'h00);
    repeat (9) sea_host_model_i.clk_pulse(s);
    check_bit("released data line", 1'b1, sda_wire);
    set_addr(8'h12, 8'h00);
    rx(d[2], 1'b0);
    sea_host_model_i.stop_cond();
    write_protect <= 1'b1;
    sea_host_model_i.start_cond();
    tx(dev_w, 1'b1);
    tx(8'h12, 1'b1);
    tx(8'h00, 1'b1);
    tx(~d[2], 1'b1);
    sea_host_model_i.stop_cond();
    levels(1'b1, 1'b0);
    write_protect <= 1'b0;
    set_addr(8'h12, 8'h00);
    rx(d[2], 1'b0);
    sea_host_model_i.stop_cond();
    repeat (4) @(posedge clock);
    stop_test();
  end
endmodule : tb_top
